// [verilog/kam_irq.sv]
// key input and address match interrupt sources with a wishbone register file
// What this block does
// - a selected edge on any of four key pins raises the key request.
// - a detected key edge pulses a wake-up for wait or stop mode.
// - one enable bit per key pin; disabled pins never make key requests.
// - one polarity bit per pin; 0 means falling edge, 1 means rising edge.
// - an enabled falling-edge pin held low blocks edges on the other pins.
// - an enabled rising-edge pin held high blocks edges on the other pins.
// - fetch address equal to a compare value raises an address match request.
// - each of the two comparators has its own enable; disabled ones stay quiet.
// - address match requests ignore the interrupt enable flag and priority level.
// - long or listed short-immediate instructions save compare address plus two.
// - all other matched instructions save compare address plus one.
// - acknowledge reads the vector word and clears the acknowledged request flag.
// - a program read of the vector word clears the top enabled pending flag.
// - stack pointer is zero after reset; software loads it before interrupts.
// - changing enable or polarity may set the flag; software clears it after.
// - rewriting non-flag fields must not lose requests; use read-modify-write.
//
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/100ps
`include "kam_cfg.svh"
module kam_irq (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // key pins, asynchronous
    input  wire logic [3:0]  key_pin_i,
    // processor fetch and acknowledge
    input  wire logic        fetch_valid_i,
    input  wire logic [19:0] fetch_addr_i,
    input  wire logic        fetch_long_i,
    input  wire logic        key_ack_i,
    input  wire logic [1:0]  amatch_ack_i,
    input  wire logic        vec_prog_rd_i,
    // requests and saved state
    output logic             key_req_o,
    output logic [2:0]       key_level_o,
    output logic             wake_o,
    output logic [1:0]       amatch_req_o,
    output logic [19:0]      amatch_pc_o,
    output logic [15:0]      sp_o
);

    // ==============================================================
    // state and combinational helpers
    kam_pkg::kam_state_s st;
    kam_pkg::kam_state_s next_st;
    logic [3:0]  act;
    logic [3:0]  key_edge;
    logic [1:0]  am_hit;
    logic        acc;
    logic        wr;
    logic [31:0] wmask;
    logic [31:0] rdat;
    logic [31:0] wv;
    logic [3:0]  agree;
    logic        key_clr;
    logic [1:0]  am_clr;
    logic [19:0] pc_inc;

    // ==============================================================
    // key pin activity and edge detection
    always_comb
    begin
        act = st.key_en & ~(st.lvl ^ st.key_pol);
        // a held active pin blocks the others
        for (int i = 0; i < 4; i++)
        begin
            key_edge[i] = act[i] & ~st.act_prev[i] & ~(|(st.act_prev & ~(4'h1 << i)));
        end
    end

    // ==============================================================
    // address comparators
    always_comb
    begin
        // fetch address compared with both values
        // each comparator has its own enable
        am_hit[0] = fetch_valid_i & st.am_en[0] & (fetch_addr_i == st.am_val0);
        am_hit[1] = fetch_valid_i & st.am_en[1] & (fetch_addr_i == st.am_val1);
        // long forms return past two bytes
        // other forms return past one byte
        pc_inc = fetch_long_i ? `KAM_PC_INC_LONG : `KAM_PC_INC_SHORT;
    end

    // ==============================================================
    // bus decode and read mux
    always_comb
    begin
        // ack high in the answer cycle keeps a held request from being taken twice
        acc   = wb_cyc_i & wb_stb_i & ~st.ack;
        wr    = acc & wb_we_i;
        wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        unique case (wb_adr_i)
            `KAM_OFF_KEY_CFG:  rdat = {24'h00_0000, st.key_pol, st.key_en};
            `KAM_OFF_AM_EN:    rdat = {30'h000_0000, st.am_en};
            `KAM_OFF_AM_VAL0:  rdat = {12'h000, st.am_val0};
            `KAM_OFF_AM_VAL1:  rdat = {12'h000, st.am_val1};
            `KAM_OFF_KEY_CTL:  rdat = {28'h000_0000, st.key_flag, st.key_level};
            `KAM_OFF_AM_FLAG:  rdat = {30'h000_0000, st.am_flag};
            `KAM_OFF_KEY_STAT: rdat = {24'h00_0000, st.act_prev, st.lvl};
            `KAM_OFF_SP:       rdat = {16'h0000, st.sp};
            default:           rdat = 32'h0000_0000;
        endcase
        // byte lanes merged over the current contents
        wv = (rdat & ~wmask) | (wb_dat_i & wmask);
    end

    // ==============================================================
    // next state
    always_comb
    begin
        next_st = st;
        // three-stage synchroniser; level moves once stages two and three agree
        // stage one may be metastable, so only stages two and three feed the filter
        next_st.s1  = key_pin_i;
        next_st.s2  = st.s1;
        next_st.s3  = st.s2;
        agree       = ~(st.s2 ^ st.s3);
        next_st.lvl = (agree & st.s3) | (~agree & st.lvl);
        // a config change that makes a pin active counts as an edge
        next_st.act_prev = act;
        // wake pulse on every accepted key edge
        next_st.wake = |key_edge;

        // program vector read clears the enabled pending key flag
        // a bus write clears it only with an explicit zero in the flag bit
        key_clr = key_ack_i | (vec_prog_rd_i & (st.key_level != 3'h0))
                | (wr & (wb_adr_i == `KAM_OFF_KEY_CTL) & ~wv[`KAM_KEY_FLAG_BIT]);
        // set wins over any clear in the same cycle
        next_st.key_flag = (st.key_flag & ~key_clr) | (|key_edge);

        am_clr = amatch_ack_i
               | ({2{wr & (wb_adr_i == `KAM_OFF_AM_FLAG)}} & ~wv[1:0]);
        // match flags are sticky, set over clear
        next_st.am_flag = (st.am_flag & ~am_clr) | am_hit;
        // lower comparator wins the saved address when both hit
        if (am_hit[0])
        begin
            next_st.am_pc = st.am_val0 + pc_inc;
        end
        else if (am_hit[1])
        begin
            next_st.am_pc = st.am_val1 + pc_inc;
        end

        // field writes never drop a flag that is being set
        if (wr)
        begin
            unique case (wb_adr_i)
                `KAM_OFF_KEY_CFG:
                begin
                    next_st.key_en  = wv[`KAM_KEY_EN_LSB +: 4];
                    next_st.key_pol = wv[`KAM_KEY_POL_LSB +: 4];
                end
                `KAM_OFF_AM_EN:   next_st.am_en     = wv[1:0];
                `KAM_OFF_AM_VAL0: next_st.am_val0   = wv[19:0];
                `KAM_OFF_AM_VAL1: next_st.am_val1   = wv[19:0];
                `KAM_OFF_KEY_CTL: next_st.key_level = wv[`KAM_KEY_LVL_LSB +: 3];
                `KAM_OFF_SP:      next_st.sp        = wv[15:0];
                default:          next_st.sp        = st.sp;
            endcase
        end

        // one-cycle ack; unmapped reads return zero
        next_st.ack = acc;
        next_st.dat = (acc & ~wb_we_i) ? rdat : 32'h0000_0000;
    end

    // ==============================================================
    // state register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st           <= '0;
            // pin stages start at the idle high level, so no false edge follows reset
            st.s1        <= `KAM_RST_PIN;
            st.s2        <= `KAM_RST_PIN;
            st.s3        <= `KAM_RST_PIN;
            st.lvl       <= `KAM_RST_PIN;
            st.key_en    <= `KAM_RST_KEY_EN;
            st.key_pol   <= `KAM_RST_KEY_POL;
            st.key_level <= `KAM_RST_KEY_LEVEL;
            st.am_en     <= `KAM_RST_AM_EN;
            st.am_val0   <= `KAM_RST_AM_VAL;
            st.am_val1   <= `KAM_RST_AM_VAL;
            st.sp        <= `KAM_RST_SP;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ==============================================================
    // outputs, each straight from the state register
    assign wb_dat_o     = st.dat;
    assign wb_ack_o     = st.ack;
    assign key_req_o    = st.key_flag;
    assign key_level_o  = st.key_level;
    assign wake_o       = st.wake;
    // no enable-flag or priority gating on match requests
    assign amatch_req_o = st.am_flag;
    assign amatch_pc_o  = st.am_pc;
    assign sp_o         = st.sp;

    // ==============================================================
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence am_hit0_s;
        fetch_valid_i && st.am_en[0] && (fetch_addr_i == st.am_val0);
    endsequence

    sequence bus_req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    key_flag_set_a: assert property ((|key_edge) |=> key_req_o)
        else $error("key edge did not raise the request");

    key_wake_a: assert property ((|key_edge) |=> wake_o ##1 !wake_o)
        else $error("wake pulse missing or too long");

    key_cause_a: assert property (!key_req_o ##1 key_req_o |-> $past(|(key_edge & st.key_en)))
        else $error("key flag set without an enabled edge");

    key_fall_a: assert property ((st.key_en[0] && !st.key_pol[0] && $fell(st.lvl[0])
        && $stable(st.key_en) && $stable(st.key_pol) && st.act_prev == 4'h0)
        |=> key_req_o)
        else $error("falling edge on pin 0 not detected");

    key_block_a: assert property ((st.act_prev != 4'h0) |-> (key_edge == 4'h0))
        else $error("edge accepted while another pin is held active");

    key_hold_a: assert property (key_req_o && !key_ack_i && !vec_prog_rd_i && !wr |=> key_req_o)
        else $error("key flag dropped without a clear");

    am_match_a: assert property (am_hit0_s |=> amatch_req_o[0])
        else $error("address match 0 not flagged");

    am_off_a: assert property (!st.am_en[1] && !amatch_req_o[1] |=> !amatch_req_o[1])
        else $error("disabled comparator raised a request");

    am_pc_short_a: assert property (am_hit0_s and !fetch_long_i
        |=> amatch_pc_o == $past(st.am_val0) + `KAM_PC_INC_SHORT)
        else $error("short form saved wrong address");

    am_pc_long_a: assert property (am_hit0_s and fetch_long_i
        |=> amatch_pc_o == $past(st.am_val0) + `KAM_PC_INC_LONG)
        else $error("long form saved wrong address");

    vec_clear_a: assert property (key_req_o && vec_prog_rd_i && key_level_o != 3'h0
        && key_edge == 4'h0 |=> !key_req_o)
        else $error("vector read did not clear the key flag");

    ack_clear_a: assert property (key_ack_i && key_edge == 4'h0 |=> !key_req_o)
        else $error("acknowledge did not clear the key flag");

    sp_reset_a: assert property ($past(rst_i) |-> sp_o == 16'h0000)
        else $error("stack pointer not zero after reset");

    // rising edge on pin 3 detected
    key_rise_a: assert property ((st.key_en[3] && st.key_pol[3] && $rose(st.lvl[3])
        && $stable(st.key_en) && $stable(st.key_pol) && st.act_prev == 4'h0)
        |=> key_req_o)
        else $error("rising edge on pin 3 not detected");

    key_rise_block_a: assert property ((st.key_en[3] && st.key_pol[3] && st.act_prev[3])
        |-> (key_edge[2:0] == 3'h0))
        else $error("edge accepted while a rising pin is held high");

    am_idle_a: assert property (!st.am_en[0] && !amatch_req_o[0] |=> !amatch_req_o[0])
        else $error("disabled comparator 0 raised a request");

    wake_cause_a: assert property (wake_o |-> $past(|key_edge))
        else $error("wake pulse without a key edge");

    bus_ack_a: assert property (bus_req_s |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single cycle");

endmodule : kam_irq

// [verilog/kam_cfg.svh]
// offsets, field positions, reset values and constants for the key / address match block
`ifndef KAM_CFG_SVH
`define KAM_CFG_SVH
// ==================================================================
// register byte offsets
`define KAM_OFF_KEY_CFG    8'h00
`define KAM_OFF_AM_EN      8'h04
`define KAM_OFF_AM_VAL0    8'h08
`define KAM_OFF_AM_VAL1    8'h0C
`define KAM_OFF_KEY_CTL    8'h10
`define KAM_OFF_AM_FLAG    8'h14
`define KAM_OFF_KEY_STAT   8'h18
`define KAM_OFF_SP         8'h1C
// ==================================================================
// field positions
`define KAM_KEY_EN_LSB     0
`define KAM_KEY_POL_LSB    4
`define KAM_KEY_LVL_LSB    0
`define KAM_KEY_FLAG_BIT   3
`define KAM_STAT_ACT_LSB   4
// ==================================================================
// reset values
`define KAM_RST_KEY_EN     4'h0
`define KAM_RST_KEY_POL    4'h0
`define KAM_RST_KEY_LEVEL  3'h0
`define KAM_RST_PIN        4'hF
`define KAM_RST_AM_EN      2'h0
`define KAM_RST_AM_VAL     20'h0_0000
`define KAM_RST_SP         16'h0000
// ==================================================================
// saved program counter offsets
`define KAM_PC_INC_LONG    20'h0_0002
`define KAM_PC_INC_SHORT   20'h0_0001
`endif

// [verilog/kam_pkg.sv]
// types for the key / address match block
package kam_pkg;
    // ==============================================================
    // whole state of the block
    typedef struct packed {
        logic [3:0]  s1;
        logic [3:0]  s2;
        logic [3:0]  s3;
        logic [3:0]  lvl;
        logic [3:0]  act_prev;
        logic [3:0]  key_en;
        logic [3:0]  key_pol;
        logic [2:0]  key_level;
        logic        key_flag;
        logic [1:0]  am_en;
        logic [1:0]  am_flag;
        logic [19:0] am_val0;
        logic [19:0] am_val1;
        logic [19:0] am_pc;
        logic [15:0] sp;
        logic        wake;
        logic        ack;
        logic [31:0] dat;
    } kam_state_s;
endpackage : kam_pkg

// [tb/kam_keys.sv]
// key switch model standing on the four key pins
`timescale 1ns/100ps
module kam_keys (
    // switch contacts, high while pressed
    input  wire logic [3:0] press_i,
    // pins to the block
    output logic      [3:0] key_pin_o
);
    // ==============================================================
    // switches to ground with pull-ups: a released pin sits high
    assign key_pin_o = ~press_i;
endmodule : kam_keys

// [tb/tb_kam_irq.sv]
// self-checking bench for the key input and address match block
`timescale 1ns/100ps
module tb_kam_irq;
    // ==============================================================
    // design signals, named after the ports
    logic        clk_i = 1'b0, rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hF, key_pin_i, press = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q, r;
    logic        wb_ack_o, fetch_valid_i = 1'b0, fetch_long_i = 1'b0;
    logic [19:0] fetch_addr_i = 20'h0_0000, amatch_pc_o;
    logic        key_ack_i = 1'b0, vec_prog_rd_i = 1'b0, key_req_o, wake_o;
    logic [1:0]  amatch_ack_i = 2'h0, amatch_req_o;
    logic [2:0]  key_level_o;
    logic [15:0] sp_o;
    int          failures = 0, comparisons = 0;
    // ==============================================================
    // design and key switches
    kam_irq u_kam_irq (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .key_pin_i, .fetch_valid_i,
        .fetch_addr_i, .fetch_long_i, .key_ack_i, .amatch_ack_i, .vec_prog_rd_i,
        .key_req_o, .key_level_o, .wake_o, .amatch_req_o, .amatch_pc_o, .sp_o);
    kam_keys u_kam_keys (.press_i(press), .key_pin_o(key_pin_i));
    // 40 MHz clock
    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end
    // ==============================================================
    // helpers
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        begin
            n = 0;
            @(posedge clk_i);
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i  <= w;
            wb_adr_i <= a;
            wb_dat_i <= d;
            // hold everything; look at ack where it has settled, release at the next edge
            do
            begin
                @(negedge clk_i);
                n++;
            end
            while (wb_ack_o !== 1'b1 && n < 20);
            q = wb_dat_o;
            @(posedge clk_i);
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            if (n >= 20)
            begin
                failures++;
                $display("MISMATCH at %0t: bus ack timed out", $time);
            end
        end
    endtask : wb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            comparisons++;
            if (got !== exp)
            begin
                failures++;
                $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask : chk
    // bit 0: request seen, bit 1: wake pulse seen, over a fixed window
    task automatic watch();
        begin
            r = 32'h0000_0000;
            // sampled mid-cycle so a one-cycle pulse cannot race the edge
            repeat (12)
            begin
                @(negedge clk_i);
                r[0] = r[0] | key_req_o;
                r[1] = r[1] | wake_o;
            end
            @(posedge clk_i);
        end
    endtask : watch
    task automatic fetch(input logic [19:0] a, input logic l);
        begin
            @(posedge clk_i);
            fetch_valid_i <= 1'b1;
            fetch_addr_i  <= a;
            fetch_long_i  <= l;
            @(posedge clk_i);
            fetch_valid_i <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
    endtask : fetch
    // ==============================================================
    // scenarios
    task automatic t_reset();
        begin
            chk({16'h0000, sp_o}, 32'h0000_0000);
            wb(1'b0, 8'h1C, 32'h0000_0000);
            chk(q, 32'h0000_0000);
            wb(1'b1, 8'h1C, 32'h0000_1234);
            wb(1'b0, 8'h1C, 32'h0000_0000);
            chk(q, 32'h0000_1234);
            // only byte lane zero written
            wb_sel_i <= 4'h1;
            wb(1'b1, 8'h1C, 32'h0000_AB56);
            wb_sel_i <= 4'hF;
            wb(1'b0, 8'h1C, 32'h0000_0000);
            chk(q, 32'h0000_1256);
            chk({16'h0000, sp_o}, 32'h0000_1256);
            // unmapped place reads zero
            wb(1'b0, 8'h40, 32'h0000_0000);
            chk(q, 32'h0000_0000);
        end
    endtask : t_reset
    task automatic t_key_fall();
        begin
            wb(1'b1, 8'h00, 32'h0000_0003);
            wb(1'b1, 8'h10, 32'h0000_0001);
            press <= 4'b0001;
            watch();
            chk(r, 32'h0000_0003);
            wb(1'b0, 8'h10, 32'h0000_0000);
            chk(q, 32'h0000_0009);
            chk({29'h0, key_level_o}, 32'h0000_0001);
            @(posedge clk_i);
            vec_prog_rd_i <= 1'b1;
            @(posedge clk_i);
            vec_prog_rd_i <= 1'b0;
            repeat (2) @(posedge clk_i);
            chk({31'h0, key_req_o}, 32'h0000_0000);
            press <= 4'b0011;
            watch();
            chk(r, 32'h0000_0000);
            press <= 4'b0000;
            watch();
            chk(r, 32'h0000_0000);
            press <= 4'b0100;
            watch();
            chk(r, 32'h0000_0000);
            press <= 4'b0010;
            watch();
            chk(r, 32'h0000_0003);
            @(posedge clk_i);
            key_ack_i <= 1'b1;
            @(posedge clk_i);
            key_ack_i <= 1'b0;
            repeat (2) @(posedge clk_i);
            chk({31'h0, key_req_o}, 32'h0000_0000);
            press <= 4'b0000;
            repeat (6) @(posedge clk_i);
        end
    endtask : t_key_fall
    task automatic t_key_rise();
        begin
            // pin 3 idles high, so enabling it rising makes a request
            wb(1'b1, 8'h00, 32'h0000_0088);
            watch();
            chk(r & 32'h1, 32'h0000_0001);
            press <= 4'b0100;
            wb(1'b1, 8'h00, 32'h0000_00CC);
            wb(1'b1, 8'h10, 32'h0000_0001);
            press <= 4'b0000;
            watch();
            chk(r, 32'h0000_0000);
            press <= 4'b1100;
            watch();
            press <= 4'b1000;
            watch();
            chk(r, 32'h0000_0003);
        end
    endtask : t_key_rise
    task automatic t_match();
        begin
            wb(1'b1, 8'h08, 32'h0001_2345);
            wb(1'b1, 8'h0C, 32'h0000_0ABC);
            wb(1'b1, 8'h04, 32'h0000_0001);
            fetch(20'h0_0ABC, 1'b1);
            chk({30'h0, amatch_req_o}, 32'h0000_0000);
            fetch(20'h1_2345, 1'b1);
            chk({30'h0, amatch_req_o}, 32'h0000_0001);
            chk({12'h000, amatch_pc_o}, 32'h0001_2347);
            wb(1'b1, 8'h04, 32'h0000_0003);
            fetch(20'h0_0ABC, 1'b0);
            chk({30'h0, amatch_req_o}, 32'h0000_0003);
            chk({12'h000, amatch_pc_o}, 32'h0000_0ABD);
            @(posedge clk_i);
            amatch_ack_i <= 2'h1;
            @(posedge clk_i);
            amatch_ack_i <= 2'h0;
            repeat (2) @(posedge clk_i);
            chk({30'h0, amatch_req_o}, 32'h0000_0002);
            wb(1'b1, 8'h14, 32'h0000_0000);
            wb(1'b0, 8'h14, 32'h0000_0000);
            chk(q, 32'h0000_0000);
        end
    endtask : t_match
    // ==============================================================
    // verdict
    task automatic summarize();
        begin
            $display("comparisons %0d failures %0d", comparisons, failures);
            if (failures == 0 && comparisons > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask : summarize
    // watchdog, far beyond the expected run
    initial
    begin
        #(25 * 20000);
        failures++;
        summarize();
    end
    // main sequence
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        t_reset();
        t_key_fall();
        t_key_rise();
        t_match();
        // no watchdog source here, nothing to restart
        summarize();
    end
endmodule : tb_kam_irq
